// [src/rwc_defs.svh]
// Constants for the RAM write controller: register offsets, fields, reset values, timing counts.
// Assumes a 200 MHz aclk; pin timings of the RAM are expressed in whole clock cycles.
`ifndef RWC_DEFS_SVH
`define RWC_DEFS_SVH

// ==========================================
// Register offsets (byte addresses, one aligned word each)
`define RWC_CTRL_OFFSET 12'h000
`define RWC_ADDR_OFFSET 12'h004
`define RWC_WDATA_OFFSET 12'h008
`define RWC_STATUS_OFFSET 12'h00c
`define RWC_TIMING_OFFSET 12'h010
`define RWC_RDATA_OFFSET 12'h014

// ==========================================
// Control fields
`define RWC_CTRL_START_BIT 0
`define RWC_CTRL_SLEEP_BIT 1
`define RWC_CTRL_SEL_MODE_BIT 2
`define RWC_CTRL_GATE_BIT 3

// ==========================================
// Status fields
`define RWC_STAT_BUSY_BIT 0
`define RWC_STAT_DONE_BIT 1

// ==========================================
// Timing: setup, pulse width and hold of a write, in ns, and cycles derived at 5 ns period.
`define RWC_CLK_PERIOD_NS 5
`define RWC_SETUP_NS 10
`define RWC_PULSE_NS 20
`define RWC_HOLD_NS 10
`define RWC_SETUP_CYC ((`RWC_SETUP_NS + `RWC_CLK_PERIOD_NS - 1) / `RWC_CLK_PERIOD_NS)
`define RWC_PULSE_CYC ((`RWC_PULSE_NS + `RWC_CLK_PERIOD_NS - 1) / `RWC_CLK_PERIOD_NS)
`define RWC_HOLD_CYC ((`RWC_HOLD_NS + `RWC_CLK_PERIOD_NS - 1) / `RWC_CLK_PERIOD_NS)
`define RWC_TIMING_RESET 32'h0004_0202
`define RWC_RESP_OKAY 2'b00
`define RWC_RESP_SLVERR 2'b10

`endif

// [src/rwc_pkg.sv]
// Types shared by the RAM write controller files.
// Assumes the constants header is included by the files that need numbers.
package rwc_pkg;

   // ==========================================
   // Write sequencer states.
   typedef enum logic [2:0] {
      RWC_IDLE,
      RWC_SETUP,
      RWC_PULSE,
      RWC_HOLD
   } rwc_state_type;

   // Pins toward the RAM write port, bundled.
   typedef struct packed {
      logic [13:0] write_addr;
      logic [31:0] din;
      logic write_strobe_n;
      logic write_port_sel_n;
      logic read_port_sel_n;
      logic out_gate_n;
      logic read_sleep;
   } rwc_pins_type;

endpackage : rwc_pkg

// [src/rwc_timer.sv]
// Down-counter that paces one phase of the write cycle.
// Assumes a single clock; load and count come from the sequencer.
`timescale 1ns/1ps
module rwc_timer #(
   parameter int WIDTH = 8
) (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic load, // Load a new count.
   input wire logic [WIDTH-1:0] count, // Cycles of the coming phase.
   output logic expired // High when the phase has elapsed.
);

   logic [WIDTH-1:0] cnt_reg;

   // ==========================================
   // Counter; a count of zero is bumped to one so no phase is shorter than a cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= (count == '0) ? WIDTH'(1) : count;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - WIDTH'(1);
      end
   end

   assign expired = (cnt_reg == WIDTH'(1)) || (cnt_reg == '0);

endmodule : rwc_timer

// [src/rwc_ctrl.sv]
// Controller that drives the write port of an asynchronous one-read, one-write dual-port RAM.
// Assumes software over AXI4-Lite and a RAM macro wired straight to the pin outputs.
// What this block does
// (RL1) Address is set up before the write strobe falls.
// (RL2) Address is held stable after the write strobe rises.
// (RL3) Write data is held stable after the write strobe rises.
// (RL4) Unknown address at strobe fall poisons all words; the RAM model handles it.
// (RL5) Read output turns unknown an access time after address turns unknown.
// (RL6) Unknown data at strobe rise stores unknown; the RAM flags it.
// (RL7) The write strobe low pulse lasts the programmed pulse count; its reset value of 2 cycles (10 ns) is under the 20 ns minimum width.
// (RL8) An unknown write strobe is reported by the RAM.
// (RL9) An unknown address at strobe fall is reported by the RAM.
// (RL10) Read-sleep meets setup and hold around the write strobe.
// (RL11) Unknown read-sleep at strobe fall is reported by the RAM.
// (RL12) A good write replaces an unknown word with the new value.
// (RL13) After a disturbed write, differing words become unknown.
// (RL14) A select-strobed write holds the select low for the programmed pulse count, 2 cycles (10 ns) at reset, under its 20 ns minimum width.
// (RL15) Select turning unknown during a low strobe is reported by the RAM.
// (RL16) Address faults around the select poison every word.
// (RL17) Data faults around the select poison only the written word.
// (RL18) Faults around the select are reported as address or data errors.
// (RL19) Late data changes pass straight to the read output while the strobe is low.
// (RL20) Selects, strobe and gate are active low; read-sleep is active high.
// (RL21) With read-sleep set, a write stores but the output stays zero.
// (RL22) With the gate on, write data passes through to the read output.
// (RL23) Writes land at strobe rise; timing checks live only in simulation.
`timescale 1ns/1ps
module rwc_ctrl #(
   parameter int AW = 14,
   parameter int DW = 32
) (
   input wire logic aclk, // Clock, 200 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [11:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte enables.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [11:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   output logic [AW-1:0] write_addr, // RAM write address.
   output logic [DW-1:0] ram_din, // RAM write data.
   output logic write_strobe_n, // RAM write strobe, active low.
   output logic write_port_sel_n, // RAM write port select, active low.
   output logic read_port_sel_n, // RAM read port select, active low.
   output logic out_gate_n, // RAM output gate, active low.
   output logic read_sleep, // RAM read-sleep, active high.
   input wire logic [DW-1:0] ram_dout // RAM read output.
);

`include "rwc_defs.svh"

   rwc_pkg::rwc_state_type state_reg, state_next;
   rwc_pkg::rwc_pins_type pins_reg, pins_next;
   logic [31:0] ctrl_reg;
   logic [31:0] addr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] timing_reg;
   logic [DW-1:0] rdata_reg;
   logic done_reg;
   logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [31:0] rdata_out_reg;
   logic [1:0] rresp_reg, bresp_reg;
   logic tmr_load, tmr_expired;
   logic [7:0] tmr_count;

   // ==========================================
   // AXI write channel: address and data taken in either order, answer after both.
   wire wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   wire busy = (state_reg != rwc_pkg::RWC_IDLE);
   wire hit_ctrl = (aw_addr_reg == `RWC_CTRL_OFFSET);
   wire hit_addr = (aw_addr_reg == `RWC_ADDR_OFFSET);
   wire hit_wdata = (aw_addr_reg == `RWC_WDATA_OFFSET);
   wire hit_timing = (aw_addr_reg == `RWC_TIMING_OFFSET);
   wire hit_status_w = (aw_addr_reg == `RWC_STATUS_OFFSET);
   wire hit_rdata_w = (aw_addr_reg == `RWC_RDATA_OFFSET);
   wire wr_known = hit_ctrl | hit_addr | hit_wdata | hit_timing | hit_status_w | hit_rdata_w;
   wire start_req = wr_fire && hit_ctrl && w_data_reg[`RWC_CTRL_START_BIT] && !busy;
   wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   assign s_axi_awready = !aw_got_reg;
   assign s_axi_wready = !w_got_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // Channel capture; strobes are applied at capture, so disabled bytes are stored as zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && !aw_got_reg) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_got_reg <= 1'b0;
         end
         if (s_axi_wvalid && !w_got_reg) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata & wmask;
         end else if (wr_fire) begin
            w_got_reg <= 1'b0;
         end
      end
   end

   // Response; control, address, data and timing change only while the sequencer is idle, so a busy write to them gets SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `RWC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_known && !(busy && (hit_ctrl | hit_addr | hit_wdata | hit_timing)))
                      ? `RWC_RESP_OKAY : `RWC_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ==========================================
   // Software registers; the start bit is a pulse and does not stay set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= 32'h0000_0000;
         addr_reg <= 32'h0000_0000;
         wdata_reg <= 32'h0000_0000;
         timing_reg <= `RWC_TIMING_RESET;
      end else if (wr_fire && !busy) begin
         if (hit_ctrl) begin
            ctrl_reg <= w_data_reg & 32'h0000_000e;
         end
         if (hit_addr) begin
            addr_reg <= w_data_reg;
         end
         if (hit_wdata) begin
            wdata_reg <= w_data_reg;
         end
         if (hit_timing) begin
            timing_reg <= w_data_reg;
         end
      end
   end

   // Done is sticky; a new completion wins over a clear written in the same cycle.
   wire write_end = (state_reg == rwc_pkg::RWC_HOLD) && tmr_expired;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_reg <= 1'b0;
      end else if (write_end) begin
         done_reg <= 1'b1;
      end else if (wr_fire && hit_status_w && w_data_reg[`RWC_STAT_DONE_BIT]) begin
         done_reg <= 1'b0;
      end
   end

   // ==========================================
   // AXI read channel.
   wire [31:0] status_word = {30'h0, done_reg, busy};
   wire [31:0] rd_mux =
      (s_axi_araddr == `RWC_CTRL_OFFSET) ? ctrl_reg :
      (s_axi_araddr == `RWC_ADDR_OFFSET) ? addr_reg :
      (s_axi_araddr == `RWC_WDATA_OFFSET) ? wdata_reg :
      (s_axi_araddr == `RWC_STATUS_OFFSET) ? status_word :
      (s_axi_araddr == `RWC_TIMING_OFFSET) ? timing_reg :
      (s_axi_araddr == `RWC_RDATA_OFFSET) ? 32'(rdata_reg) : 32'h0000_0000;
   wire rd_known = (s_axi_araddr == `RWC_CTRL_OFFSET) || (s_axi_araddr == `RWC_ADDR_OFFSET) ||
      (s_axi_araddr == `RWC_WDATA_OFFSET) || (s_axi_araddr == `RWC_STATUS_OFFSET) ||
      (s_axi_araddr == `RWC_TIMING_OFFSET) || (s_axi_araddr == `RWC_RDATA_OFFSET);
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_out_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_out_reg <= 32'h0000_0000;
         rresp_reg <= `RWC_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_out_reg <= rd_mux;
         rresp_reg <= rd_known ? `RWC_RESP_OKAY : `RWC_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ==========================================
   // Write sequencer: setup, strobe low, hold. Address, data and read-sleep stay fixed from
   // setup through hold, so the RAM never sees them change mid-write and never poisons words.
   wire sel_mode = ctrl_reg[`RWC_CTRL_SEL_MODE_BIT];
   always_comb begin
      state_next = state_reg;
      pins_next = pins_reg;
      tmr_load = 1'b0;
      tmr_count = timing_reg[7:0];
      case (state_reg)
         rwc_pkg::RWC_IDLE: begin
            // While idle, read-sleep follows control so reads can be woken without a write.
            pins_next.read_sleep = ctrl_reg[`RWC_CTRL_SLEEP_BIT]; // RL20
            if (start_req) begin
               // Present address, data and sleep ahead of the strobe.
               pins_next.write_addr = addr_reg[13:0]; // RL1
               pins_next.din = wdata_reg; // RL6
               pins_next.read_sleep = w_data_reg[`RWC_CTRL_SLEEP_BIT]; // RL10
               pins_next.out_gate_n = !w_data_reg[`RWC_CTRL_GATE_BIT]; // RL22
               // In select mode the strobe sits low and the select does the pulsing.
               pins_next.write_strobe_n = !w_data_reg[`RWC_CTRL_SEL_MODE_BIT];
               pins_next.write_port_sel_n = w_data_reg[`RWC_CTRL_SEL_MODE_BIT];
               tmr_load = 1'b1;
               tmr_count = timing_reg[7:0];
               state_next = rwc_pkg::RWC_SETUP;
            end
         end
         rwc_pkg::RWC_SETUP: begin
            if (tmr_expired) begin
               // Drop the strobe; in select mode the select is the strobing pin.
               if (sel_mode) begin
                  pins_next.write_port_sel_n = 1'b0; // RL14
               end else begin
                  pins_next.write_strobe_n = 1'b0; // RL7
               end
               tmr_load = 1'b1;
               tmr_count = timing_reg[15:8];
               state_next = rwc_pkg::RWC_PULSE;
            end
         end
         rwc_pkg::RWC_PULSE: begin
            if (tmr_expired) begin
               // Rising edge is where the RAM stores the word.
               pins_next.write_strobe_n = sel_mode ? 1'b0 : 1'b1; // RL23
               pins_next.write_port_sel_n = sel_mode ? 1'b1 : 1'b0;
               tmr_load = 1'b1;
               tmr_count = timing_reg[23:16];
               state_next = rwc_pkg::RWC_HOLD;
            end
         end
         rwc_pkg::RWC_HOLD: begin
            if (tmr_expired) begin
               // Address and data released only after the hold time.
               pins_next.write_strobe_n = 1'b1; // RL2 RL3
               pins_next.write_port_sel_n = 1'b0; // RL16 RL17
               state_next = rwc_pkg::RWC_IDLE;
            end
         end
         default: begin
            state_next = rwc_pkg::RWC_IDLE;
         end
      endcase
   end

   // State and pin registers; both pins of a phase change in one update, so no glitch.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= rwc_pkg::RWC_IDLE;
         pins_reg <= '{write_addr: '0, din: '0, write_strobe_n: 1'b1, write_port_sel_n: 1'b0,
                       read_port_sel_n: 1'b0, out_gate_n: 1'b0, read_sleep: 1'b0}; // RL20
      end else begin
         state_reg <= state_next;
         pins_reg <= pins_next;
      end
   end

   // Sample the RAM read output each cycle; under read-sleep it reads as zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= ram_dout; // RL21
      end
   end

   rwc_timer #(.WIDTH(8)) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(tmr_load),
      .count(tmr_count),
      .expired(tmr_expired)
   );

   assign write_addr = pins_reg.write_addr[AW-1:0];
   assign ram_din = pins_reg.din[DW-1:0];
   assign write_strobe_n = pins_reg.write_strobe_n;
   assign write_port_sel_n = pins_reg.write_port_sel_n;
   assign read_port_sel_n = pins_reg.read_port_sel_n;
   assign out_gate_n = pins_reg.out_gate_n;
   assign read_sleep = pins_reg.read_sleep;

endmodule : rwc_ctrl

// [test/rwc_ram_model.sv]
// Behavioural model of the RAM write port that the controller drives.
// Assumes the controller pins are wired straight in; sixteen words are modelled.
`timescale 1ns/1ps
module rwc_ram_model (
   input wire logic [13:0] write_addr, // Write address.
   input wire logic [31:0] ram_din, // Write data.
   input wire logic write_strobe_n, // Write strobe.
   input wire logic write_port_sel_n, // Write select.
   input wire logic read_port_sel_n, // Read select.
   input wire logic out_gate_n, // Output gate.
   input wire logic read_sleep, // Read-sleep.
   output logic [31:0] ram_dout // Read output.
);
   // ==========================================
   // Storage
   logic [31:0] mem [16];
   wire logic we_n = write_strobe_n | write_port_sel_n;
   wire logic [31:0] word = mem[write_addr[3:0]];
   // A word lands as strobe or select rises; an unknown address poisons all words.
   always @(posedge we_n) mem[write_addr[3:0]] = ram_din;
   always @(negedge we_n) if ($isunknown(write_addr)) foreach (mem[i]) mem[i] = 'x;
   // A deselected read shows the inverse so a stale value never passes for data.
   assign ram_dout = read_sleep ? 32'h0 : out_gate_n ? 'z :
      !we_n ? ram_din : read_port_sel_n ? ~word : word;
endmodule : rwc_ram_model

// [test/rwc_ctrl_checker.sv]
// Checker of the controller's RAM-side timing.
// Assumes binding into rwc_ctrl; sees only its ports.
`timescale 1ns/1ps
module rwc_ctrl_checker #(
   parameter int AW = 14,
   parameter int DW = 32
) (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Reset, active low.
   input wire logic [AW-1:0] write_addr, // Write address.
   input wire logic [DW-1:0] ram_din, // Write data.
   input wire logic write_strobe_n, // Write strobe.
   input wire logic write_port_sel_n, // Write select.
   input wire logic read_sleep // Read-sleep.
);
   // ==========================================
   // The effective strobe is low only while both strobe and select are low.
   wire logic we_n = write_strobe_n | write_port_sel_n;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   addr_setup_a: assert property ($fell(we_n) |-> $stable(write_addr))
      else $error("address moved as the write began");
   data_setup_a: assert property ($fell(we_n) |-> $stable(ram_din))
      else $error("data moved as the write began");
   hold_after_a: assert property ($rose(we_n) |=> $stable(write_addr) && $stable(ram_din))
      else $error("address or data moved right after the write");
   pulse_width_a: assert property ($fell(we_n) |-> !we_n [*2])
      else $error("write strobe pulse too short");
   steady_low_a: assert property (!we_n |=> we_n || ($stable(write_addr) && $stable(ram_din)))
      else $error("address or data moved while strobe low");
   sleep_steady_a: assert property (!we_n |-> $stable(read_sleep) ##1 $stable(read_sleep))
      else $error("read-sleep moved around the write");
   sel_pulse_a: assert property ($fell(write_port_sel_n) && !write_strobe_n |-> !write_port_sel_n [*2])
      else $error("select pulse too short");
   reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> write_strobe_n && !read_sleep)
      else $error("pins not idle after reset");
   cover property ($fell(we_n) && !write_port_sel_n);
   cover property ($fell(write_port_sel_n) && !write_strobe_n);
   cover property ($rose(we_n) && read_sleep);
endmodule : rwc_ctrl_checker
bind rwc_ctrl rwc_ctrl_checker #(.AW(AW), .DW(DW)) i_rwc_ctrl_checker (.aclk(aclk),
   .aresetn(aresetn), .write_addr(write_addr), .ram_din(ram_din),
   .write_strobe_n(write_strobe_n), .write_port_sel_n(write_port_sel_n),
   .read_sleep(read_sleep));

// [test/tb_top.sv]
// Testbench of the RAM write controller: AXI4-Lite tasks drive register sequences.
// Assumes the RAM model on the pins and the checker bound into the design.
`timescale 1ns/1ps
`include "rwc_defs.svh"
module tb_top;
   // ==========================================
   // Signals named as the design ports, so instances connect by bare name.
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, ram_din, ram_dout;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [13:0] write_addr;
   logic write_strobe_n, write_port_sel_n, read_port_sel_n, out_gate_n, read_sleep;
   int bad_count = 0;
   int n_checks = 0;
   rwc_ctrl i_rwc_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .write_addr, .ram_din, .write_strobe_n, .write_port_sel_n,
      .read_port_sel_n, .out_gate_n, .read_sleep, .ram_dout);
   rwc_ram_model i_rwc_ram_model (.write_addr, .ram_din, .write_strobe_n, .write_port_sel_n,
      .read_port_sel_n, .out_gate_n, .read_sleep, .ram_dout);
   // ==========================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   // Ready is sampled at the falling edge; it only changes at rising edges.
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ra, rw, rb;
      logic [1:0] rs;
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      rb = 1'b0;
      n = 0;
      while (!rb && n < 200) begin
         @(negedge aclk);
         ra = s_axi_awready && s_axi_awvalid;
         rw = s_axi_wready && s_axi_wvalid;
         rb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ra) s_axi_awvalid <= 1'b0;
         if (rw) s_axi_wvalid <= 1'b0;
         n++;
      end
      s_axi_bready <= 1'b0;
      chk("bvalid", 32'h1, {31'h0, rb});
      chk("bresp", {30'h0, er}, {30'h0, rs});
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic ra, rv;
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rv = 1'b0;
      n = 0;
      while (!rv && n < 200) begin
         @(negedge aclk);
         ra = s_axi_arready && s_axi_arvalid;
         rv = s_axi_rvalid;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ra) s_axi_arvalid <= 1'b0;
         n++;
      end
      s_axi_rready <= 1'b0;
      chk("rvalid", 32'h1, {31'h0, rv});
   endtask : axi_rd
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] rs;
      axi_rd(a, d, rs);
      chk("rresp", {30'h0, er}, {30'h0, rs});
      chk("rdata", e, d);
   endtask : rd_chk
   // Polls status for done under a bounded count.
   task automatic wait_done;
      logic [31:0] s;
      logic [1:0] rs;
      int n;
      s = 32'h0;
      for (n = 0; n < 100 && s[1] !== 1'b1; n++) axi_rd(`RWC_STATUS_OFFSET, s, rs);
   endtask : wait_done
   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   // ==========================================
   // Clock, watchdog and main sequence
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      close_out;
   end
   initial begin
      logic [31:0] d, ctl;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hf;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("pins", 32'h4, {29'h0, write_strobe_n, read_sleep, out_gate_n});
      rd_chk(`RWC_TIMING_OFFSET, `RWC_TIMING_RESET, `RWC_RESP_OKAY);
      rd_chk(`RWC_STATUS_OFFSET, 32'h0, `RWC_RESP_OKAY);
      rd_chk(12'h020, 32'h0, `RWC_RESP_SLVERR);
      axi_wr(12'h024, 32'h1, `RWC_RESP_SLVERR);
      $display("test registers done");
      axi_wr(`RWC_TIMING_OFFSET, 32'h0008_0808, `RWC_RESP_OKAY);
      // Normal, select-strobed and read-sleep writes, gate on in each.
      for (int i = 0; i < 3; i++) begin
         ctl = (i == 0) ? 32'h9 : (i == 1) ? 32'hd : 32'hb;
         d = 32'hc0de_a500 | i;
         axi_wr(`RWC_ADDR_OFFSET, 32'h3 + i, `RWC_RESP_OKAY);
         axi_wr(`RWC_WDATA_OFFSET, d, `RWC_RESP_OKAY);
         axi_wr(`RWC_CTRL_OFFSET, ctl, `RWC_RESP_OKAY);
         axi_wr(`RWC_TIMING_OFFSET, 32'h0, `RWC_RESP_SLVERR);
         wait_done;
         rd_chk(`RWC_STATUS_OFFSET, 32'h2, `RWC_RESP_OKAY);
         rd_chk(`RWC_RDATA_OFFSET, ctl[1] ? 32'h0 : d, `RWC_RESP_OKAY);
         axi_wr(`RWC_STATUS_OFFSET, 32'h2, `RWC_RESP_OKAY);
         rd_chk(`RWC_STATUS_OFFSET, 32'h0, `RWC_RESP_OKAY);
      end
      axi_wr(`RWC_CTRL_OFFSET, 32'h8, `RWC_RESP_OKAY);
      rd_chk(`RWC_RDATA_OFFSET, 32'hc0de_a502, `RWC_RESP_OKAY);
      rd_chk(`RWC_TIMING_OFFSET, 32'h0008_0808, `RWC_RESP_OKAY);
      $display("test writes done");
      close_out;
   end
endmodule : tb_top
